// file: design/fet_control_defines.svh
// Offsets, bit positions, reset values and timing counts for the switch control block
`ifndef FET_CONTROL_DEFINES_SVH
`define FET_CONTROL_DEFINES_SVH

`define ADDR_POWER_SWITCH_CONTROL       8'h04
`define ADDR_DISCHARGE_PROTECTION_CFG   8'h05

`define BIT_FORCE_SLEEP                 7
`define BIT_LOAD_MONITOR_ENABLE         6
`define BIT_CHARGE_SWITCH_ON            1
`define BIT_DISCHARGE_SWITCH_ON         0
`define MASK_POWER_SWITCH_CONTROL       8'hc3

`define RESET_POWER_SWITCH_CONTROL      8'h00
`define RESET_DISCHARGE_PROTECTION_CFG  8'h00

`define CLK_FREQ_KHZ                    40000
`define OCD_BASE_TIME_MS                160
`define OCD_BASE_CYCLES                 (`OCD_BASE_TIME_MS * `CLK_FREQ_KHZ)
`define OCD_DIVIDE_SHIFT                6
`define OCD_CNT_WIDTH                   26

`endif

// file: design/fet_control_pkg.sv
// Types for the switch control and discharge protection registers
package fet_control_pkg;

    typedef struct packed {
        logic       force_sleep;
        logic       load_monitor_enable;
        logic [3:0] reserved;
        logic       charge_switch_on;
        logic       discharge_switch_on;
    } power_switch_control_t;

    typedef struct packed {
        logic       discharge_oc_autooff_disable;
        logic [1:0] discharge_oc_threshold;
        logic       short_autooff_disable;
        logic [1:0] short_threshold;
        logic [1:0] discharge_oc_delay;
    } discharge_protection_config_t;

    typedef struct packed {
        logic discharge_oc_detect;
        logic short_detect;
        logic charge_oc_fault;
        logic wake_event;
        logic status_read;
    } fault_inputs_t;

    typedef enum logic {
        ST_AWAKE,
        ST_ASLEEP
    } power_state_t;

endpackage

// file: design/fet_control_discharge_config.sv
// Switch control and discharge protection configuration registers
// Operation
// - Writing one to bit 7 of switch control forces sleep.
// - Forced sleep turns off both switch outputs and the regulator.
// - Forced sleep clears charge, discharge and all cell balance enables.
// - Force-sleep bit clears itself on wake.
// - Forced sleep leaves the analog output selection untouched.
// - Bit 6 switches the load voltage monitor on or off, software only.
// - Bit 1 drives the charge switch on or off.
// - Charge overcurrent clears charge bit unless its auto-off is disabled.
// - Bit 0 drives the discharge switch on or off.
// - Discharge overcurrent or short clears discharge bit unless disabled.
// - Bit 7 zero: discharge overcurrent turns switches off; one: untouched.
// - Discharge overcurrent always sets its flag and thermistor supply.
// - Bits 6:5 pick 0.10, 0.12, 0.14 or 0.16 V.
// - Bit 4 zero: short turns switches off; one: no turn-off.
// - Short always sets its flag and thermistor supply.
// - Bits 3:2 pick 0.20, 0.35, 0.65 or 1.20 V.
// - Bits 1:0 give 160, 320, 640 ms, divided 2.5, 5, 10 ms.
// - Registers keep contents in sleep, supply moved to bottom cell.
// - Divide bit set divides the discharge delay by 64.
// - Discharge overcurrent flag clears on status read once condition gone.
`timescale 1ns/1ps
`include "fet_control_defines.svh"

module fet_control_discharge_config #(
    parameter int OCD_BASE_CYCLES = `OCD_BASE_CYCLES,
    parameter int CNT_WIDTH       = `OCD_CNT_WIDTH
) (
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_wr,
    output logic [7:0]                         reg_rdata,
    input  wire fet_control_pkg::fault_inputs_t faults,
    input  wire logic                          discharge_delay_divide,
    input  wire logic                          charge_oc_autooff_disable,
    output logic                               charge_switch_on,
    output logic                               discharge_switch_on,
    output logic                               regulator_enable,
    output logic                               load_voltage_monitor,
    output logic                               cell_balance_clear,
    output logic                               retention_supply_bottom_cell,
    output logic [1:0]                         discharge_oc_threshold_sel,
    output logic [1:0]                         short_threshold_sel,
    output logic                               discharge_overcurrent_flag,
    output logic                               short_circuit_flag,
    output logic                               thermistor_supply_out
);
    import fet_control_pkg::*;

    power_switch_control_t        ctrl;
    discharge_protection_config_t cfg;
    power_state_t                 state;
    logic [CNT_WIDTH-1:0]         ocd_cnt;
    logic [CNT_WIDTH-1:0]         ocd_limit;
    logic                         ocd_fault;
    logic                         sleep_req;
    logic                         wr_ctrl;
    logic                         wr_cfg;
    logic                         auto_off;
    logic [CNT_WIDTH-1:0]         det_run;
    logic [CNT_WIDTH-1:0]         exp_limit;

    // Elaboration range check
    if (OCD_BASE_CYCLES < 64 || CNT_WIDTH > 31
        || (longint'(OCD_BASE_CYCLES) * 4) >= (64'h1 << CNT_WIDTH))
    begin : g_range_check
        $error("OCD_BASE_CYCLES or CNT_WIDTH out of range");
    end

    // =====================================================
    // Delay decode
    function automatic logic [CNT_WIDTH-1:0] delay_cycles(input logic [1:0] code,
                                                          input logic       divide);
        logic [CNT_WIDTH-1:0] base;
        base = CNT_WIDTH'(OCD_BASE_CYCLES);
        case (code)
            2'h0:    delay_cycles = base;
            2'h1:    delay_cycles = base << 1;
            default: delay_cycles = base << 2;
        endcase
        if (divide)
            delay_cycles = delay_cycles >> `OCD_DIVIDE_SHIFT;
    endfunction

    assign ocd_limit = delay_cycles(cfg.discharge_oc_delay, discharge_delay_divide);

    // =====================================================
    // Register access
    // Full byte writes
    assign wr_ctrl   = reg_wr && reg_addr == `ADDR_POWER_SWITCH_CONTROL;
    assign wr_cfg    = reg_wr && reg_addr == `ADDR_DISCHARGE_PROTECTION_CFG;
    assign sleep_req = wr_ctrl && reg_wdata[`BIT_FORCE_SLEEP];

    always_comb
    begin
        case (reg_addr)
            `ADDR_POWER_SWITCH_CONTROL:     reg_rdata = ctrl & `MASK_POWER_SWITCH_CONTROL;
            `ADDR_DISCHARGE_PROTECTION_CFG: reg_rdata = cfg;
            default:                        reg_rdata = 8'h00;
        endcase
    end

    // =====================================================
    // Overcurrent qualification
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ocd_cnt <= '0;
        else if (!faults.discharge_oc_detect)
            ocd_cnt <= '0;
        else if (ocd_cnt < ocd_limit)
            ocd_cnt <= ocd_cnt + 1'b1;
    end

    assign ocd_fault = faults.discharge_oc_detect && ocd_cnt == ocd_limit - 1'b1;

    assign auto_off = (ocd_fault && !cfg.discharge_oc_autooff_disable)
                   || (faults.short_detect && !cfg.short_autooff_disable);

    // =====================================================
    // Configuration register
    // Held through sleep
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            cfg <= `RESET_DISCHARGE_PROTECTION_CFG;
        else if (wr_cfg)
            cfg <= reg_wdata;
    end

    // =====================================================
    // Switch control register
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ctrl <= `RESET_POWER_SWITCH_CONTROL;
        else
        begin
            if (wr_ctrl)
            begin
                ctrl.load_monitor_enable <= reg_wdata[`BIT_LOAD_MONITOR_ENABLE];
                ctrl.charge_switch_on    <= reg_wdata[`BIT_CHARGE_SWITCH_ON];
                ctrl.discharge_switch_on <= reg_wdata[`BIT_DISCHARGE_SWITCH_ON];
                if (reg_wdata[`BIT_FORCE_SLEEP])
                    ctrl.force_sleep <= 1'b1;
            end
            ctrl.reserved <= 4'h0;
            if (faults.charge_oc_fault && !charge_oc_autooff_disable)
                ctrl.charge_switch_on <= 1'b0;
            if (auto_off)
            begin
                ctrl.charge_switch_on    <= 1'b0;
                ctrl.discharge_switch_on <= 1'b0;
            end
            if (sleep_req)
            begin
                ctrl.charge_switch_on    <= 1'b0;
                ctrl.discharge_switch_on <= 1'b0;
            end
            if (state == ST_ASLEEP && faults.wake_event)
                ctrl.force_sleep <= 1'b0;
        end
    end

    // =====================================================
    // Power state
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state <= ST_AWAKE;
        else
        begin
            case (state)
                ST_AWAKE:  if (sleep_req) state <= ST_ASLEEP;
                ST_ASLEEP: if (faults.wake_event) state <= ST_AWAKE;
                default:   state <= ST_AWAKE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            cell_balance_clear <= 1'b0;
        else
            cell_balance_clear <= sleep_req;
    end

    // =====================================================
    // Fault flags
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            discharge_overcurrent_flag <= 1'b0;
        else if (ocd_fault)
            discharge_overcurrent_flag <= 1'b1;
        else if (faults.status_read && !faults.discharge_oc_detect)
            discharge_overcurrent_flag <= 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            short_circuit_flag <= 1'b0;
        else if (faults.short_detect)
            short_circuit_flag <= 1'b1;
        else if (faults.status_read)
            short_circuit_flag <= 1'b0;
    end

    // =====================================================
    // Outputs
    // Thermistor supply
    assign thermistor_supply_out = discharge_overcurrent_flag || short_circuit_flag;
    assign charge_switch_on      = ctrl.charge_switch_on && state == ST_AWAKE;
    assign discharge_switch_on   = ctrl.discharge_switch_on && state == ST_AWAKE;
    assign regulator_enable      = state == ST_AWAKE;
    assign retention_supply_bottom_cell = state == ST_ASLEEP;
    assign load_voltage_monitor  = ctrl.load_monitor_enable;
    assign discharge_oc_threshold_sel = cfg.discharge_oc_threshold;
    assign short_threshold_sel        = cfg.short_threshold;

    // =====================================================
    // Assertions
    // Delay reference
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            det_run <= '0;
        else if (!faults.discharge_oc_detect)
            det_run <= '0;
        else if (det_run != '1)
            det_run <= det_run + 1'b1;
    end

    assign exp_limit = (CNT_WIDTH'(OCD_BASE_CYCLES)
                        << (cfg.discharge_oc_delay == 2'h0 ? 0
                            : cfg.discharge_oc_delay == 2'h1 ? 1 : 2))
                       >> (discharge_delay_divide ? `OCD_DIVIDE_SHIFT : 0);

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_SLEEP_ENTER: assert property (sleep_req |=> state == ST_ASLEEP && ctrl.force_sleep)
        else $error("force sleep did not enter sleep");
    AST_SLEEP_OFF: assert property (state == ST_ASLEEP |-> !charge_switch_on
        && !discharge_switch_on && !regulator_enable)
        else $error("outputs on during sleep");
    AST_SLEEP_CLEAR: assert property (sleep_req |=> !ctrl.charge_switch_on
        && !ctrl.discharge_switch_on && cell_balance_clear)
        else $error("sleep did not clear switch bits");
    AST_WAKE_CLEAR: assert property (state == ST_ASLEEP && faults.wake_event
        |=> !ctrl.force_sleep && state == ST_AWAKE)
        else $error("sleep bit not cleared on wake");
    AST_MONITOR: assert property (wr_ctrl |=> load_voltage_monitor
        == $past(reg_wdata[`BIT_LOAD_MONITOR_ENABLE]))
        else $error("monitor bit mismatch");
    AST_CHARGE_OFF: assert property (faults.charge_oc_fault
        && !charge_oc_autooff_disable |=> !ctrl.charge_switch_on)
        else $error("charge switch not cleared");
    AST_OCD_OFF: assert property (ocd_fault && !cfg.discharge_oc_autooff_disable
        |=> !discharge_switch_on && !charge_switch_on)
        else $error("discharge overcurrent did not open switches");
    AST_SHORT_KEEP: assert property (faults.short_detect && cfg.short_autooff_disable
        && !ocd_fault && !faults.charge_oc_fault && !wr_ctrl && !sleep_req
        && state == ST_AWAKE
        |=> $stable(ctrl.discharge_switch_on))
        else $error("short turned switch off while disabled");
    AST_FLAGS: assert property (ocd_fault || faults.short_detect
        |=> thermistor_supply_out)
        else $error("fault did not raise thermistor supply");
    AST_DOC_HOLD: assert property (discharge_overcurrent_flag
        && faults.discharge_oc_detect |=> discharge_overcurrent_flag)
        else $error("overcurrent flag cleared while condition present");
    AST_RESERVED: assert property (reg_addr == `ADDR_POWER_SWITCH_CONTROL
        |-> reg_rdata[5:2] == 4'h0)
        else $error("reserved bits not zero");
    AST_DELAY: assert property (ocd_fault |-> det_run == exp_limit - 1'b1
        && faults.discharge_oc_detect)
        else $error("overcurrent qualified early");
    AST_OCD_FIRE: assert property (faults.discharge_oc_detect
        && det_run == exp_limit - 1'b1 |-> ocd_fault)
        else $error("overcurrent not qualified on time");

    COV_SLEEP_WAKE: cover property (sleep_req ##[1:20] faults.wake_event);
    COV_OCD: cover property (ocd_fault);
    COV_SHORT_DIS: cover property (faults.short_detect && cfg.short_autooff_disable);
    COV_FLAG_CLEAR: cover property (discharge_overcurrent_flag ##1 !discharge_overcurrent_flag);

endmodule

// file: sim/pack_controller_model.sv
// Pack microcontroller model driving the register write port
`timescale 1ns/1ps

module pack_controller_model (
    input  wire logic       clk,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    input  wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
    end

    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask
endmodule

// file: sim/tb.sv
// Self-checking bench for the switch control and discharge configuration block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module tb;
    import fet_control_pkg::*;
    localparam int BASE = 128;
    logic          clk, sys_rst, wr, divide, coc_dis, chg, dis, reg_en, lvm, cbc, ret;
    logic          doc_f, sc_f, therm;
    logic [7:0]    addr, wdata, rdata, rd;
    logic [1:0]    oct, sct;
    logic [15:0]   seed;
    fault_inputs_t faults;
    int            fails, comparisons, m04, m05, mdoc, msc, slp, n, i;

    pack_controller_model host (.clk(clk), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rdata(rdata));

    fet_control_discharge_config #(.OCD_BASE_CYCLES(BASE)) uut (.clk(clk),
        .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
        .reg_rdata(rdata), .faults(faults), .discharge_delay_divide(divide),
        .charge_oc_autooff_disable(coc_dis), .charge_switch_on(chg),
        .discharge_switch_on(dis), .regulator_enable(reg_en), .load_voltage_monitor(lvm),
        .cell_balance_clear(cbc), .retention_supply_bottom_cell(ret),
        .discharge_oc_threshold_sel(oct), .short_threshold_sel(sct),
        .discharge_overcurrent_flag(doc_f), .short_circuit_flag(sc_f),
        .thermistor_supply_out(therm));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic end_sim();
        $display("Counts: comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr_reg(input int a, input int d);
        host.write_byte(8'(a), 8'(d));
        if (a == 5)
            m05 = d & 'hff;
        else if (a == 4 && d[7] && slp == 0)
        begin
            m04 = (d & 'h40) | 'h80;
            slp = 1;
        end
        else if (a == 4)
            m04 = d & 'hc3;
    endtask

    task automatic pulse(input int idx);
        @(posedge clk);
        faults[idx] <= 1'b1;
        @(posedge clk);
        faults[idx] <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic check_all(input string t);
        host.read_byte(8'h04, rd);
        `CHK({t, " sw reg"}, 8'(m04), rd)
        host.read_byte(8'h05, rd);
        `CHK({t, " cfg reg"}, 8'(m05), rd)
        `CHK({t, " chg"}, 1'(m04 >> 1), chg)
        `CHK({t, " dis"}, 1'(m04), dis)
        `CHK({t, " lvm"}, 1'(m04 >> 6), lvm)
        `CHK({t, " reg_en"}, 1'(!slp), reg_en)
        `CHK({t, " ret"}, 1'(slp), ret)
        `CHK({t, " oc thr"}, 2'(m05 >> 5), oct)
        `CHK({t, " sc thr"}, 2'(m05 >> 2), sct)
        `CHK({t, " doc"}, 1'(mdoc), doc_f)
        `CHK({t, " scf"}, 1'(msc), sc_f)
        `CHK({t, " therm"}, 1'(mdoc | msc), therm)
    endtask

    task automatic run_ocd(input int cfg, input logic dv);
        int lim;
        wr_reg(4, 'h43);
        wr_reg(5, cfg);
        divide <= dv;
        lim = BASE * (cfg[1:0] == 0 ? 1 : cfg[1:0] == 1 ? 2 : 4) / (dv ? 64 : 1);
        @(posedge clk);
        faults.discharge_oc_detect <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            #1 n++;
        end while (doc_f !== 1'b1 && n < lim + 8);
        `CHK("ocd delay", lim, n)
        mdoc = 1;
        if (!cfg[7])
            m04 = m04 & 'hfc;
        check_all("ocd");
        pulse(0);
        check_all("ocd held");
        @(posedge clk);
        faults.discharge_oc_detect <= 1'b0;
        pulse(0);
        mdoc = 0;
        check_all("ocd gone");
        $display("Test ocd cfg %h div %b done", cfg[7:0], dv);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        #250000;
        fails++;
        end_sim();
    end

    initial
    begin
        sys_rst = 1'b1;
        divide = 1'b0;
        coc_dis = 1'b0;
        faults = '0;
        seed = 16'd31751;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        check_all("reset");
        wr_reg(6, 'hff);
        host.read_byte(8'h07, rd);
        `CHK("unmapped", 8'h00, rd)
        wr_reg(4, 'h7f);
        check_all("sw write");
        $display("Test register access done");
        for (i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            wr_reg(5, (i << 5) | (i << 2) | (seed & 'h93));
            check_all("thresholds");
        end
        $display("Test thresholds done");
        run_ocd('h00, 1'b1);
        run_ocd('h01, 1'b0);
        run_ocd('h82, 1'b1);
        run_ocd('h03, 1'b1);
        for (i = 0; i < 2; i++)
        begin
            wr_reg(4, 'h43);
            wr_reg(5, i << 4);
            pulse(3);
            msc = 1;
            if (i == 0)
                m04 = m04 & 'hfc;
            check_all("short");
            pulse(0);
            msc = 0;
            check_all("short clr");
            @(posedge clk);
            coc_dis <= 1'(i);
            wr_reg(4, 'h43);
            pulse(2);
            if (i == 0)
                m04 = m04 & 'hfd;
            check_all("chg oc");
        end
        $display("Test short and charge fault done");
        seed = lfsr(seed);
        wr_reg(5, seed & 'hff);
        wr_reg(4, 'hc3);
        #1;
        `CHK("cb clear", 1'b1, cbc)
        @(posedge clk);
        #1;
        `CHK("cb pulse", 1'b0, cbc)
        check_all("sleep");
        pulse(1);
        m04 = m04 & 'h7f;
        slp = 0;
        check_all("wake");
        $display("Test sleep done");
        end_sim();
    end
endmodule
